// *** core/dpll_ptr_map.svh ***
/*
 Offsets, field positions, reset values and step sizes of the
 trigger/state adapt pointer bank. Assumes a [0:31] register view
 in which bit 0 is the most significant bit.
*/
`ifndef DPLL_PTR_MAP_SVH
`define DPLL_PTR_MAP_SVH

`define OFS_TRIG_ADAPT   4'h0
`define OFS_STATE_ADAPT  4'h4
`define OFS_RECENT       4'h8

`define F_TPTR           20:29
`define F_SPTR           24:29
`define F_RCNT           22:31
`define B_FST            21
`define F_CUR            16:18
`define F_LAST           13:15
`define F_VIRT           7:12
`define B_WRCNT          2
`define B_WSYNC          1
`define B_WVIRT          0

`define RST_RCNT         10'h001
`define RST_SYNC         3'h1
`define FORCE_RCNT       10'h001
`define RCNT_FULL        12'h800

`define STEP_ONE         10'h001
`define CORR_FREE        10'h004
`define CORR_SMC         10'h002
`define STEP_CORR        10'h003
`define PTR_SHIFT        2
`define TRIG_ADAPT_BASE  16'h4000
`define STATE_ADAPT_BASE 16'h1000

`endif

// *** core/dpll_ptr_pkg.sv ***
/*
 Types for the trigger/state adapt pointer bank.
 Assumes the map header is compiled alongside.
*/
package dpll_ptr_pkg;

    // Register port request
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [3:0]  addr;
        logic [0:31] wdata;
    } bus_req_t;

    // Events from the loop engine, all synchronous to clk
    typedef struct packed {
        logic trigValid;
        logic trigDirection;
        logic specialModeCtrl;
        logic stateValid;
        logic stateDirection;
        logic lockLost;
    } loop_evt_t;

    // Whole block state
    typedef struct packed {
        logic [9:0]  trigAdaptPtr;
        logic [5:0]  stateAdaptPtr;
        logic [9:0]  recentTrigCount;
        logic        trigFullScaleFlag;
        logic [2:0]  curIncrEventCount;
        logic [2:0]  lastIncrEventCount;
        logic [5:0]  virtualTrigCount;
        logic        trigDirSeen;
        logic        stateDirSeen;
        logic        trigPend;
        logic        statePend;
        logic [0:31] rdata;
    } bank_state_t;

endpackage

// *** core/trigger_state_pointer_regs.sv ***
/*
 Trigger adapt pointer, state adapt pointer and recent trigger
 count control registers of the loop, with pointer stepping and
 direction correction. Assumes a single-cycle register port and
 loop events synchronous to clk; bit 0 of a register is its MSB.
*/
// Notes on behaviour
// - Trigger adapt pointer is 10 bits at 20..29, zero after reset.
// - Trigger pointer steps by one with each valid trigger event.
// - Without special mode direction changes after event; with it, known before.
// - Direction change corrects pointer by four, or two in special mode.
// - RAM address is pointer at its bit place plus region base.
// - Reserved bits read zero; software writes zero.
// - State adapt pointer is 6 bits at 24..29, zero after reset.
// - State pointer steps on event, plus double correction after direction change.
// - Recent count is software set, forced to one on trigger direction change or lock loss.
// - Recent count zero means full scale, not zero events.
// - Recent count and full-scale flag write only with enable bit 2.
// - Current increment count writes only with enable bit 1.
// - Writing current increment count moves old value to last count.
// - Virtual count writes only with enable bit 0; enables read zero.
// - Past distance is recent count minus virtual count.
`timescale 1ns/1ps
`include "dpll_ptr_map.svh"

module trigger_state_pointer_regs
    import dpll_ptr_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        nrst,
    input  wire bus_req_t    req,
    input  wire loop_evt_t   evt,
    output logic      [0:31] rdata,
    output logic      [9:0]  trigAdaptPtr,
    output logic      [5:0]  stateAdaptPtr,
    output logic      [15:0] trigRamAddr,
    output logic      [15:0] stateRamAddr,
    output logic      [11:0] recentEffective,
    output logic      [11:0] pastTrigDistance,
    output logic             trigFullScaleFlag
);

    ////////////////////////////////////////////////////////////////
    // Helpers

    // Pointer move with wrap, up or down
    function automatic logic [9:0] movePtr(input logic [9:0] p,
                                           input logic       down,
                                           input logic [9:0] amt);
        movePtr = down ? p - amt : p + amt;
    endfunction

    // Word aligned RAM address of a pointer within its region
    function automatic logic [15:0] ramAddr(input logic [15:0] base,
                                            input logic [9:0]  ptr);
        ramAddr = base + (16'({6'h00, ptr}) << `PTR_SHIFT);
    endfunction

    bank_state_t q;
    bank_state_t d;
    logic        trigChg;
    logic        stateChg;
    logic        wrTrig;
    logic        wrState;
    logic        wrRecent;
    logic        forceOne;
    logic [9:0]  trigAmt;
    logic        stateCorr;

    ////////////////////////////////////////////////////////////////
    // Event and access decode
    assign trigChg  = evt.trigDirection != q.trigDirSeen;
    assign stateChg = evt.stateDirection != q.stateDirSeen;
    assign wrTrig   = req.wr && (req.addr == `OFS_TRIG_ADAPT);
    assign wrState  = req.wr && (req.addr == `OFS_STATE_ADAPT);
    assign wrRecent = req.wr && (req.addr == `OFS_RECENT);
    assign forceOne = trigChg || evt.lockLost;

    // Trigger step size: step, plus correction chosen by mode
    always_comb begin
        trigAmt = '0;
        if (evt.trigValid) begin
            trigAmt = `STEP_ONE;
            if (evt.specialModeCtrl && (q.trigPend || trigChg)) begin
                trigAmt = `STEP_CORR;
            end
        end
        // Change seen after the event: correct at once, four places
        if (trigChg && !evt.specialModeCtrl) begin
            trigAmt = trigAmt + `CORR_FREE;
        end
    end

    assign stateCorr = q.statePend || stateChg;

    ////////////////////////////////////////////////////////////////
    // Next state
    always_comb begin
        d = q;
        d.rdata = '0;
        d.trigDirSeen  = evt.trigDirection;
        d.stateDirSeen = evt.stateDirection;

        // Trigger pointer; a special mode change waits for the event
        d.trigAdaptPtr = movePtr(q.trigAdaptPtr, evt.trigDirection, trigAmt);
        if (evt.specialModeCtrl && trigChg && !evt.trigValid) begin
            d.trigPend = 1'b1;
        end else if (evt.trigValid || !evt.specialModeCtrl) begin
            d.trigPend = 1'b0;
        end

        // State pointer: direction is always known before the event
        if (evt.stateValid) begin
            d.stateAdaptPtr = 6'(movePtr({4'h0, q.stateAdaptPtr},
                                         evt.stateDirection,
                                         stateCorr ? `STEP_CORR : `STEP_ONE));
            d.statePend = 1'b0;
        end else if (stateChg) begin
            d.statePend = 1'b1;
        end

        // Software load of the pointers overrides a same-cycle step
        if (wrTrig) begin
            d.trigAdaptPtr = req.wdata[`F_TPTR];
        end
        if (wrState) begin
            d.stateAdaptPtr = req.wdata[`F_SPTR];
        end

        // Each field group gated by its own enable bit; recent count and full-scale flag share bit 2
        if (wrRecent && req.wdata[`B_WRCNT]) begin
            d.recentTrigCount   = req.wdata[`F_RCNT];
            d.trigFullScaleFlag = req.wdata[`B_FST];
        end
        if (wrRecent && req.wdata[`B_WSYNC]) begin
            d.curIncrEventCount  = req.wdata[`F_CUR];
            d.lastIncrEventCount = q.curIncrEventCount;
        end
        if (wrRecent && req.wdata[`B_WVIRT]) begin
            d.virtualTrigCount = req.wdata[`F_VIRT];
        end
        // Hardware force beats a software write in the same cycle
        if (forceOne) begin
            d.recentTrigCount = `FORCE_RCNT;
        end

        // Read view; reserved and enable bits stay zero
        if (req.rd) begin
            case (req.addr)
                `OFS_TRIG_ADAPT: begin
                    d.rdata[`F_TPTR] = q.trigAdaptPtr;
                end
                `OFS_STATE_ADAPT: begin
                    d.rdata[`F_SPTR] = q.stateAdaptPtr;
                end
                `OFS_RECENT: begin
                    d.rdata[`F_RCNT] = q.recentTrigCount;
                    d.rdata[`B_FST]  = q.trigFullScaleFlag;
                    d.rdata[`F_CUR]  = q.curIncrEventCount;
                    d.rdata[`F_LAST] = q.lastIncrEventCount;
                    d.rdata[`F_VIRT] = q.virtualTrigCount;
                end
                default: begin
                    d.rdata = '0;
                end
            endcase
        end
    end

    // State register; direction history starts at forward
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            q <= '0;
            q.recentTrigCount    <= `RST_RCNT;
            q.curIncrEventCount  <= `RST_SYNC;
            q.lastIncrEventCount <= `RST_SYNC;
        end else begin
            q <= d;
        end
    end

    ////////////////////////////////////////////////////////////////
    // Outputs
    assign rdata             = q.rdata;
    assign trigAdaptPtr      = q.trigAdaptPtr;
    assign stateAdaptPtr     = q.stateAdaptPtr;
    assign trigFullScaleFlag = q.trigFullScaleFlag;
    assign trigRamAddr  = ramAddr(`TRIG_ADAPT_BASE, q.trigAdaptPtr);
    assign stateRamAddr = ramAddr(`STATE_ADAPT_BASE, {4'h0, q.stateAdaptPtr});
    // Zero stands for the full history depth
    assign recentEffective = (q.recentTrigCount == '0) ? `RCNT_FULL
                                                       : {2'b00, q.recentTrigCount};
    // Virtual count applies to the past position only
    assign pastTrigDistance = recentEffective - {6'h00, q.virtualTrigCount};

    ////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    sequence s_plainTrig;
        evt.trigValid && !trigChg && !q.trigPend && !wrTrig;
    endsequence

    sequence s_smcChange;
        evt.specialModeCtrl && trigChg && !evt.trigValid && !wrTrig;
    endsequence

    sequence s_smcEvent;
        evt.specialModeCtrl && evt.trigValid && !trigChg && !wrTrig;
    endsequence

    property p_trig_step;
        s_plainTrig |=> q.trigAdaptPtr ==
            movePtr($past(q.trigAdaptPtr), $past(evt.trigDirection), `STEP_ONE);
    endproperty
    a_trig_step: assert property (p_trig_step) else $error("trigger step wrong");

    property p_trig_corr_free;
        !evt.specialModeCtrl && trigChg && !evt.trigValid && !wrTrig |=>
            q.trigAdaptPtr ==
            movePtr($past(q.trigAdaptPtr), $past(evt.trigDirection), `CORR_FREE);
    endproperty
    a_trig_corr_free: assert property (p_trig_corr_free) else $error("four fold fix wrong");

    property p_trig_corr_smc;
        s_smcChange ##1 s_smcEvent |=> q.trigAdaptPtr ==
            movePtr($past(q.trigAdaptPtr), $past(evt.trigDirection), `STEP_CORR);
    endproperty
    a_trig_corr_smc: assert property (p_trig_corr_smc) else $error("two fold fix wrong");

    property p_state_corr;
        stateChg && !evt.stateValid && !wrState ##1
        evt.stateValid && !stateChg && !wrState |=> q.stateAdaptPtr ==
            6'(movePtr({4'h0, $past(q.stateAdaptPtr)}, $past(evt.stateDirection),
                       `STEP_CORR));
    endproperty
    a_state_corr: assert property (p_state_corr) else $error("state fix wrong");

    property p_force_one;
        forceOne |=> q.recentTrigCount == `FORCE_RCNT;
    endproperty
    a_force_one: assert property (p_force_one) else $error("recent count not forced");

    property p_recent_guard;
        wrRecent && !req.wdata[`B_WRCNT] && !forceOne |=>
            $stable(q.recentTrigCount) && $stable(q.trigFullScaleFlag);
    endproperty
    a_recent_guard: assert property (p_recent_guard) else $error("unguarded write");

    property p_sync_shift;
        wrRecent && req.wdata[`B_WSYNC] |=>
            q.lastIncrEventCount == $past(q.curIncrEventCount) &&
            q.curIncrEventCount == $past(req.wdata[`F_CUR]);
    endproperty
    a_sync_shift: assert property (p_sync_shift) else $error("sync shift wrong");

    property p_read_zero;
        req.rd && req.addr == `OFS_RECENT |=>
            rdata[`B_WVIRT] == 1'b0 && rdata[`B_WSYNC] == 1'b0 &&
            rdata[`B_WRCNT] == 1'b0 && rdata[`F_RCNT] == $past(q.recentTrigCount);
    endproperty
    a_read_zero: assert property (p_read_zero) else $error("read view wrong");

    property p_full_scale;
        q.recentTrigCount == '0 |-> recentEffective == `RCNT_FULL &&
            pastTrigDistance == `RCNT_FULL - {6'h00, q.virtualTrigCount};
    endproperty
    a_full_scale: assert property (p_full_scale) else $error("full scale wrong");

    // Software load must win over any same-cycle step or correction
    property p_trig_load;
        wrTrig |=> q.trigAdaptPtr == $past(req.wdata[`F_TPTR]);
    endproperty
    a_trig_load: assert property (p_trig_load) else $error("trigger load lost");

    property p_state_load;
        wrState |=> q.stateAdaptPtr == $past(req.wdata[`F_SPTR]);
    endproperty
    a_state_load: assert property (p_state_load) else $error("state load lost");

    // Plain state step, no pending or fresh direction change
    property p_state_step;
        evt.stateValid && !stateChg && !q.statePend && !wrState |=> q.stateAdaptPtr ==
            6'(movePtr({4'h0, $past(q.stateAdaptPtr)}, $past(evt.stateDirection),
                       `STEP_ONE));
    endproperty
    a_state_step: assert property (p_state_step) else $error("state step wrong");

    // Enabled fields take the written value; the force is left out here
    property p_recent_load;
        wrRecent && req.wdata[`B_WRCNT] && !forceOne |=>
            q.recentTrigCount == $past(req.wdata[`F_RCNT]) &&
            q.trigFullScaleFlag == $past(req.wdata[`B_FST]);
    endproperty
    a_recent_load: assert property (p_recent_load) else $error("recent load lost");

    property p_virt_load;
        wrRecent && req.wdata[`B_WVIRT] |=>
            q.virtualTrigCount == $past(req.wdata[`F_VIRT]);
    endproperty
    a_virt_load: assert property (p_virt_load) else $error("virtual load lost");

    // Read data stands one cycle only, so stale words never leak
    property p_read_idle;
        !req.rd |=> rdata == '0;
    endproperty
    a_read_idle: assert property (p_read_idle) else $error("read data left standing");

endmodule

// *** test/trigger_state_pointer_regs_test.sv ***
/*
 Self-checking bench for the trigger/state adapt pointer bank.
 Assumes the package and map header are compiled first and that
 the register port answers reads in the cycle after the strobe.
*/
`timescale 1ns/1ps
`include "dpll_ptr_map.svh"

module trigger_state_pointer_regs_test
    import dpll_ptr_pkg::*;
;
    logic        clk;
    logic        nrst;
    bus_req_t    req;
    loop_evt_t   evt;
    logic [0:31] rdata;
    logic [9:0]  trigAdaptPtr;
    logic [5:0]  stateAdaptPtr;
    logic [15:0] trigRamAddr;
    logic [15:0] stateRamAddr;
    logic [11:0] recentEffective;
    logic [11:0] pastTrigDistance;
    logic        trigFullScaleFlag;
    int          fails;
    int          cmp_count;
    logic [0:31] w;
    logic [0:31] d;

    trigger_state_pointer_regs DUT (
        .clk              (clk),
        .nrst             (nrst),
        .req              (req),
        .evt              (evt),
        .rdata            (rdata),
        .trigAdaptPtr     (trigAdaptPtr),
        .stateAdaptPtr    (stateAdaptPtr),
        .trigRamAddr      (trigRamAddr),
        .stateRamAddr     (stateRamAddr),
        .recentEffective  (recentEffective),
        .pastTrigDistance (pastTrigDistance),
        .trigFullScaleFlag(trigFullScaleFlag)
    );

    ////////////////////////////////////////////////////////////////
    // Clock, 5 ns period
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    // Control word image, fields in the [0:31] view
    function automatic logic [0:31] mk(input logic [9:0] rc, input logic fs,
                                       input logic [2:0] cu, input logic [2:0] la,
                                       input logic [5:0] vt);
        logic [0:31] x;
        x = '0;
        x[22:31] = rc;
        x[21] = fs;
        x[16:18] = cu;
        x[13:15] = la;
        x[7:12] = vt;
        return x;
    endfunction

    task automatic chkw(input logic [0:31] got, input logic [0:31] exp);
        cmp_count++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] %0t word %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chkv(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] %0t value %h expected %h", $time, got, exp);
        end
    endtask

    ////////////////////////////////////////////////////////////////
    // Bus tasks; an idle cycle follows each strobe so no signal is set twice
    task automatic wr_reg(input logic [3:0] a, input logic [0:31] dat);
        @(posedge clk);
        req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: dat};
        @(posedge clk);
        req <= '0;
        #1;
    endtask

    task automatic rd_reg(input logic [3:0] a, output logic [0:31] dat);
        @(posedge clk);
        req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
        @(posedge clk);
        req <= '0;
        #1;
        dat = rdata;
    endtask

    // Loop event: levels stay, pulses drop after one cycle
    task automatic ev(input logic tv, input logic td, input logic special_mode_ctrl,
                      input logic sv, input logic sd, input logic ll);
        @(posedge clk);
        evt <= '{trigValid: tv, trigDirection: td, specialModeCtrl: special_mode_ctrl,
                 stateValid: sv, stateDirection: sd, lockLost: ll};
        @(posedge clk);
        evt.trigValid <= 1'b0;
        evt.stateValid <= 1'b0;
        evt.lockLost <= 1'b0;
        #1;
    endtask

    task automatic wrap_up();
        if (fails == 0 && cmp_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // Watchdog, far beyond the 65 or so cycles the tests need
    initial begin
        #20000;
        fails++;
        wrap_up();
    end

    ////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        fails = 0;
        cmp_count = 0;
        nrst = 1'b0;
        req = '0;
        evt = '0;
        repeat (3) @(posedge clk);
        nrst <= 1'b1;
        rd_reg(`OFS_TRIG_ADAPT, w);   chkw(w, 32'h0);
        rd_reg(`OFS_STATE_ADAPT, w);  chkw(w, 32'h0);
        rd_reg(`OFS_RECENT, w);       chkw(w, mk(10'h1, 0, 1, 1, 0));
        rd_reg(4'hC, w);              chkw(w, 32'h0);
        // All ones: reserved bits must read back clear
        wr_reg(`OFS_TRIG_ADAPT, 32'hFFFFFFFF);
        rd_reg(`OFS_TRIG_ADAPT, w);   chkw(w, 32'h00000FFC);
        chkv(trigRamAddr, 16'h4FFC);
        wr_reg(`OFS_STATE_ADAPT, 32'hFFFFFFFF);
        rd_reg(`OFS_STATE_ADAPT, w);  chkw(w, 32'h000000FC);
        chkv(stateRamAddr, 16'h10FC);
        wr_reg(`OFS_TRIG_ADAPT, 32'h00000028);
        wr_reg(`OFS_STATE_ADAPT, 32'h00000028);
        ev(1, 0, 0, 0, 0, 0);         chkv(trigAdaptPtr, 16'h000B);
        d = mk(10'h5, 0, 0, 0, 2);
        d[2] = 1'b1;
        d[0] = 1'b1;
        wr_reg(`OFS_RECENT, d);       chkv(recentEffective, 16'h0005);
        chkv(pastTrigDistance, 16'h0003);
        // Late flip without special mode: four corrections
        ev(0, 1, 0, 0, 0, 0);         chkv(trigAdaptPtr, 16'h0007);
        chkv(recentEffective, 16'h0001);
        ev(1, 1, 0, 0, 0, 0);         chkv(trigAdaptPtr, 16'h0006);
        // Early flip in special mode waits for the event, then two corrections
        ev(0, 0, 1, 0, 0, 0);         chkv(trigAdaptPtr, 16'h0006);
        ev(1, 0, 1, 0, 0, 0);         chkv(trigAdaptPtr, 16'h0009);
        wr_reg(`OFS_RECENT, d);
        ev(0, 0, 0, 0, 0, 1);         chkv(recentEffective, 16'h0001);
        // State pointer: flip known ahead, step plus two corrections
        ev(0, 0, 0, 0, 1, 0);         chkv(stateAdaptPtr, 16'h000A);
        ev(0, 0, 0, 1, 1, 0);         chkv(stateAdaptPtr, 16'h0007);
        ev(0, 0, 0, 1, 1, 0);         chkv(stateAdaptPtr, 16'h0006);
        // Control word: enables clear, then selective enables
        wr_reg(`OFS_RECENT, mk(10'h0, 1, 5, 7, 6));
        rd_reg(`OFS_RECENT, w);       chkw(w, mk(10'h1, 0, 1, 1, 2));
        d = mk(10'h0, 1, 5, 7, 6);
        d[2] = 1'b1;
        d[0] = 1'b1;
        wr_reg(`OFS_RECENT, d);
        rd_reg(`OFS_RECENT, w);       chkw(w, mk(10'h0, 1, 1, 1, 6));
        chkv(recentEffective, 16'h0800);
        chkv({15'h0, trigFullScaleFlag}, 16'h0001);
        chkv(pastTrigDistance, 16'h07FA);
        d = mk(10'h0, 0, 5, 0, 0);
        d[1] = 1'b1;
        wr_reg(`OFS_RECENT, d);
        rd_reg(`OFS_RECENT, w);       chkw(w, mk(10'h0, 1, 5, 1, 6));
        d[16:18] = 3'h3;
        wr_reg(`OFS_RECENT, d);
        rd_reg(`OFS_RECENT, w);       chkw(w, mk(10'h0, 1, 3, 5, 6));
        // Unmapped write must not disturb anything
        wr_reg(4'hC, 32'hFFFFFFFF);
        rd_reg(`OFS_TRIG_ADAPT, w);   chkw(w, 32'h00000024);
        wrap_up();
    end
endmodule
